// [test/sbp_far_model.sv]
/*
 * Far-side model: boot memories and a display controller on the pins.
 * Assumes active-low selects and strobes from the port, one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sbp_far_model (
  input wire logic clk,
  input wire logic [20:0] bus_addr,
  input wire logic [15:0] bus_data_out,
  input wire logic display_select_n,
  input wire logic display_read_strobe_n,
  input wire logic shared_write_strobe_n,
  input wire logic boot_memory_read_strobe_n,
  input wire logic [3:0] ready_delay,
  output logic [15:0] bus_data_in,
  output logic target_ready_in,
  output logic [20:0] wr_addr,
  output logic [15:0] wr_data,
  output logic wr_disp
);
  logic [15:0] last_q = 16'h0000;
  logic [3:0] wait_q = 4'h0;
  logic drive;
  assign drive = !display_read_strobe_n || !boot_memory_read_strobe_n;
  // Released bus shows inverted data so a late capture is caught
  assign bus_data_in = drive ? bus_addr[15:0] ^ 16'h5a5a : ~last_q;
  initial begin
    target_ready_in = 1'b0;
    wr_addr = 21'h000000;
    wr_data = 16'h0000;
    wr_disp = 1'b0;
  end
  always @(posedge clk) begin
    last_q <= bus_data_in;
    wait_q <= display_select_n ? 4'h0 : wait_q + {3'h0, wait_q != 4'hf};
    target_ready_in <= !display_select_n && (wait_q >= ready_delay);
    if (!shared_write_strobe_n) begin
      wr_addr <= bus_addr;
      wr_data <= bus_data_out;
      wr_disp <= !display_select_n;
    end
  end
endmodule
`default_nettype wire

// [test/sbp_port_tb.sv]
/*
 * Self-checking bench for the external bus port.
 * Assumes the far-side model and a shortened ROM strobe count.
 */
`timescale 1ns/1ps
`default_nettype none
module sbp_port_tb;
  import sbp_pkg::*;
  localparam int RC = 4;
  logic clk = 1'b0, srst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_display = 1'b0;
  logic rsp_ready = 1'b0;
  logic [1:0] req_rom_index = 2'h0;
  logic [ADDR_W-1:0] req_addr = 21'h000000;
  logic [DATA_W-1:0] req_wdata = 16'h0000;
  logic [3:0] dly = 4'h1;
  logic req_ready, rsp_valid, bus_data_oe, display_select_n, display_read_strobe_n;
  logic shared_write_strobe_n, boot_memory_read_strobe_n, target_ready_in, wr_disp;
  logic [15:0] rsp_rdata, bus_data_in, bus_data_out, wr_data;
  logic [20:0] bus_addr, wr_addr;
  logic [3:0] boot_memory_selects_n;
  int bad_count = 0, checks = 0, scnt;
  always #5 clk = ~clk;
  sbp_port #(.ROM_CYC(RC)) u_dut (.clk, .srst, .req_valid, .req_ready, .req_write,
    .req_display, .req_rom_index, .req_addr, .req_wdata, .rsp_valid, .rsp_ready,
    .rsp_rdata, .bus_addr, .bus_data_in, .bus_data_out, .bus_data_oe, .display_select_n,
    .display_read_strobe_n, .shared_write_strobe_n, .boot_memory_selects_n,
    .boot_memory_read_strobe_n, .target_ready_in);
  sbp_far_model u_far (.clk, .bus_addr, .bus_data_out, .display_select_n,
    .display_read_strobe_n, .shared_write_strobe_n, .boot_memory_read_strobe_n,
    .ready_delay(dly), .bus_data_in, .target_ready_in, .wr_addr, .wr_data, .wr_disp);
  function automatic logic [15:0] rd(input logic [20:0] a);
    return a[15:0] ^ 16'h5a5a;
  endfunction
  task chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Called just after an edge; lim of 50 or below means a stall is expected
  task acc(input logic w, d, input logic [1:0] i, input logic [20:0] a,
           input logic [15:0] wd, input int lim);
    int n;
    n = 0;
    scnt = 0;
    req_valid = 1'b1; req_write = w; req_display = d; req_rom_index = i;
    req_addr = a; req_wdata = wd;
    while (req_ready !== 1'b1 && n < lim) begin
      @(posedge clk); #1; n++;
    end
    @(posedge clk); #1;
    req_valid = 1'b0;
    while ((req_ready !== 1'b1 || scnt == 0) && n < lim) begin
      if (!boot_memory_read_strobe_n || !display_read_strobe_n || !shared_write_strobe_n) begin
        scnt++;
        chk(bus_addr === a, "address moved");
        chk(display_select_n === !d, "display select");
        chk(boot_memory_selects_n === (d ? 4'hf : ~(4'h1 << i)), "rom select");
        chk(bus_data_oe === w && (!w || bus_data_out === wd), "write data");
        chk({display_read_strobe_n, boot_memory_read_strobe_n, shared_write_strobe_n} ===
            (w ? 3'b110 : d ? 3'b011 : 3'b101), "strobe kind");
      end
      @(posedge clk); #1; n++;
    end
    if (lim > 50 && req_ready !== 1'b1) begin
      chk(1'b0, "access timeout");
      summarize;
    end
  endtask
  task pop(input logic [15:0] e);
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 30) begin
      @(posedge clk); #1; n++;
    end
    if (rsp_valid !== 1'b1) begin
      chk(1'b0, "response timeout");
      summarize;
    end
    chk(rsp_valid === 1'b1 && rsp_rdata === e, "read data");
    rsp_ready = 1'b1;
    @(posedge clk); #1;
    rsp_ready = 1'b0;
  endtask
  task t_rom;
    for (int k = 0; k < 4; k++) begin
      acc(1'b0, 1'b0, k[1:0], 21'h1f000 + 21'(k), 16'h0000, 100);
      chk(scnt == RC, "rom strobe length");
      pop(rd(21'h1f000 + 21'(k)));
    end
    acc(1'b1, 1'b0, 2'h3, 21'h1abcd, 16'hbeef, 100);
    chk(wr_addr === 21'h1abcd && wr_data === 16'hbeef && wr_disp === 1'b0, "flash");
    $display("rom test done");
  endtask
  task t_disp;
    dly = 4'h6;
    acc(1'b0, 1'b1, 2'h2, 21'h0c0de, 16'h0000, 100);
    chk(scnt > 6, "ready not awaited");
    pop(rd(21'h0c0de));
    dly = 4'h0;
    acc(1'b1, 1'b1, 2'h1, 21'h07777, 16'h1234, 100);
    chk(wr_addr === 21'h07777 && wr_data === 16'h1234 && wr_disp === 1'b1, "lcd");
    // Back to back: the last access's ready must not end this one
    dly = 4'h6;
    acc(1'b0, 1'b1, 2'h0, 21'h0beef, 16'h0000, 100);
    chk(scnt > 6, "stale ready used");
    pop(rd(21'h0beef));
    $display("display test done");
  endtask
  task t_full;
    acc(1'b0, 1'b0, 2'h0, 21'h00111, 16'h0000, 100);
    acc(1'b0, 1'b0, 2'h1, 21'h00222, 16'h0000, 100);
    acc(1'b0, 1'b0, 2'h2, 21'h00333, 16'h0000, 20);
    chk(req_ready === 1'b0 && boot_memory_selects_n === 4'hb, "full stall");
    pop(rd(21'h00111));
    pop(rd(21'h00222));
    pop(rd(21'h00333));
    $display("buffer test done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 srst = 1'b0;
    chk({display_select_n, display_read_strobe_n, shared_write_strobe_n,
         boot_memory_read_strobe_n, boot_memory_selects_n, bus_data_oe, req_ready,
         rsp_valid} === 11'h7fa, "reset state");
    t_rom;
    t_disp;
    t_full;
    summarize;
  end
endmodule
`default_nettype wire

// [verilog/sbp_buf2.sv]
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes one synchronous clock and an active-high synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sbp_buf2 #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic rd_q, rd_d;
  logic wr_q, wr_d;
  logic push, pop;

  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    wr_d = wr_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'd1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      cnt_q <= 2'd0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
    end
  end
endmodule
`default_nettype wire

// [verilog/sbp_pkg.sv]
/*
 * Shared constants for the external memory and display bus port.
 * Assumes a 100 MHz core clock; times are converted to cycles here.
 */
package sbp_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int ROM_COUNT = 4;
  localparam int ROM_IDX_W = 2;
  localparam int CLK_PERIOD_NS = 10;
  // Least strobe width for a ROM or flash access
  localparam int ROM_ACCESS_NS = 120;
  localparam int ROM_STROBE_CYC = (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] ROM_CNT_LOAD = CNT_W'(ROM_STROBE_CYC - 1);
  localparam logic [ROM_COUNT-1:0] ROM_SEL_IDLE = 4'hf;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h000000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

  typedef enum logic [1:0] {
    SBP_IDLE = 2'b00,
    SBP_SETUP = 2'b01,
    SBP_STROBE = 2'b10,
    SBP_HOLD = 2'b11
  } sbp_state_e;
endpackage

// [verilog/sbp_port.sv]
/*
 * External bus port toward ROM/flash and a display controller.
 * Assumes requests come from core logic on clk; pins are asynchronous.
 */
// Functional notes
// - A 21-bit address is driven for every external access.
// - The 16-bit data bus carries write data out and read data back in.
// - The display select is asserted for every display access.
// - The display read strobe is asserted only while reading the display.
// - With display select active the shared write strobe writes the display.
// - With display select inactive the shared write strobe writes flash.
// - Display accesses wait for the ready input before they complete.
// - Four ROM selects exist and only the addressed one is asserted.
// - The ROM read strobe is asserted when reading a ROM.
`timescale 1ns/1ps
`default_nettype none
module sbp_port
  import sbp_pkg::*;
#(
  parameter int ROM_CYC = ROM_STROBE_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_display,
  input wire logic [ROM_IDX_W-1:0] req_rom_index,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_data_in,
  output logic [DATA_W-1:0] bus_data_out,
  output logic bus_data_oe,
  output logic display_select_n,
  output logic display_read_strobe_n,
  output logic shared_write_strobe_n,
  output logic [ROM_COUNT-1:0] boot_memory_selects_n,
  output logic boot_memory_read_strobe_n,
  input wire logic target_ready_in
);
  // Strobe counter runs down to zero, so it is loaded with one less
  localparam logic [CNT_W-1:0] CYC_LOAD = CNT_W'(ROM_CYC - 1);
  sbp_state_e state_q, state_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [ROM_IDX_W-1:0] idx_q, idx_d;
  logic write_q, write_d;
  logic disp_q, disp_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic push;
  logic buf_ready;
  logic rdy_m_q, rdy_s_q;
  logic [DATA_W-1:0] din_m_q, din_s_q;
  logic oe_d, dsel_d, drd_d, wr_d, rrd_d;
  logic [ROM_COUNT-1:0] rsel_d;

  function automatic logic [ROM_COUNT-1:0] rom_sel_n(input logic [ROM_IDX_W-1:0] idx);
    rom_sel_n = ~(ROM_COUNT'(1) << idx);
  endfunction

  // Pin inputs pass two flops before use
  always_ff @(posedge clk) begin
    if (srst) begin
      rdy_m_q <= 1'b0;
      rdy_s_q <= 1'b0;
      din_m_q <= DATA_RESET;
      din_s_q <= DATA_RESET;
    end else begin
      // Flushed while idle so a late ready from the last access is not reused
      rdy_m_q <= (state_q == SBP_IDLE) ? 1'b0 : target_ready_in;
      rdy_s_q <= (state_q == SBP_IDLE) ? 1'b0 : rdy_m_q;
      din_m_q <= bus_data_in;
      din_s_q <= din_m_q;
    end
  end

  assign req_ready = (state_q == SBP_IDLE);

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    idx_d = idx_q;
    write_d = write_q;
    disp_d = disp_q;
    cnt_d = cnt_q;
    push = 1'b0;
    case (state_q)
      SBP_IDLE: begin
        if (req_valid) begin
          addr_d = req_addr;
          wdata_d = req_wdata;
          write_d = req_write;
          disp_d = req_display;
          idx_d = req_rom_index;
          state_d = SBP_SETUP;
        end
      end
      SBP_SETUP: begin
        cnt_d = CYC_LOAD;
        state_d = SBP_STROBE;
      end
      SBP_STROBE: begin
        if (disp_q) begin
          if (rdy_s_q) begin
            rdata_d = din_s_q;
            state_d = SBP_HOLD;
          end
        end else if (cnt_q == CNT_ZERO) begin
          rdata_d = din_s_q;
          state_d = SBP_HOLD;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      SBP_HOLD: begin
        // Select stays on until read data is buffered
        push = !write_q;
        if (write_q || buf_ready) begin
          state_d = SBP_IDLE;
        end
      end
      default: state_d = SBP_IDLE;
    endcase
  end

  // Pin drives are computed from next state so they leave flops
  always_comb begin
    oe_d = (state_d != SBP_IDLE) && write_d;
    dsel_d = (state_d != SBP_IDLE) && disp_d;
    rsel_d = ((state_d != SBP_IDLE) && !disp_d) ? rom_sel_n(idx_d) : ROM_SEL_IDLE;
    drd_d = (state_d == SBP_STROBE) && disp_d && !write_d;
    wr_d = (state_d == SBP_STROBE) && write_d;
    rrd_d = (state_d == SBP_STROBE) && !disp_d && !write_d;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= SBP_IDLE;
      addr_q <= ADDR_RESET;
      wdata_q <= DATA_RESET;
      rdata_q <= DATA_RESET;
      idx_q <= '0;
      write_q <= 1'b0;
      disp_q <= 1'b0;
      cnt_q <= CNT_ZERO;
      bus_addr <= ADDR_RESET;
      bus_data_out <= DATA_RESET;
      bus_data_oe <= 1'b0;
      display_select_n <= 1'b1;
      display_read_strobe_n <= 1'b1;
      shared_write_strobe_n <= 1'b1;
      boot_memory_selects_n <= ROM_SEL_IDLE;
      boot_memory_read_strobe_n <= 1'b1;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      idx_q <= idx_d;
      write_q <= write_d;
      disp_q <= disp_d;
      cnt_q <= cnt_d;
      bus_addr <= addr_d;
      bus_data_out <= wdata_d;
      bus_data_oe <= oe_d;
      display_select_n <= ~dsel_d;
      display_read_strobe_n <= ~drd_d;
      shared_write_strobe_n <= ~wr_d;
      boot_memory_selects_n <= rsel_d;
      boot_memory_read_strobe_n <= ~rrd_d;
    end
  end

  // Lets a stalled reader hold two words without losing one
  sbp_buf2 #(.WIDTH(DATA_W)) u_rsp_buf (
    .clk(clk),
    .srst(srst),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(rdata_q),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp_rdata)
  );

  logic any_strobe;
  assign any_strobe = !display_read_strobe_n || !shared_write_strobe_n ||
                      !boot_memory_read_strobe_n;

  a_addr_driven: assert property (@(posedge clk) disable iff (srst)
    (req_valid && req_ready) |=> (bus_addr == $past(req_addr)))
    else $error("address not driven");
  a_write_data_out: assert property (@(posedge clk) disable iff (srst)
    !shared_write_strobe_n |-> (bus_data_oe && bus_data_out == wdata_q))
    else $error("write data not driven");
  a_display_select: assert property (@(posedge clk) disable iff (srst)
    (state_q != SBP_IDLE && disp_q) |-> !display_select_n) else $error("display select off");
  a_display_read: assert property (@(posedge clk) disable iff (srst)
    !display_read_strobe_n |-> (!display_select_n && !write_q && !bus_data_oe))
    else $error("display read outside display read");
  a_shared_write: assert property (@(posedge clk) disable iff (srst)
    !shared_write_strobe_n |-> (display_select_n != (boot_memory_selects_n == ROM_SEL_IDLE)))
    else $error("write strobe meaning ambiguous");
  a_ready_wait: assert property (@(posedge clk) disable iff (srst)
    (state_q == SBP_STROBE && disp_q && !rdy_s_q) |=> (state_q == SBP_STROBE))
    else $error("display access ended without ready");
  a_rom_onehot: assert property (@(posedge clk) disable iff (srst)
    (state_q != SBP_IDLE && !disp_q) |-> (boot_memory_selects_n == rom_sel_n(idx_q)))
    else $error("wrong rom select");
  a_rom_read_len: assert property (@(posedge clk) disable iff (srst)
    $fell(boot_memory_read_strobe_n) |-> !boot_memory_read_strobe_n [*3])
    else $error("rom read strobe too short");
  a_addr_stable: assert property (@(posedge clk) disable iff (srst)
    (any_strobe && $past(any_strobe)) |-> ($stable(bus_addr) && $stable(boot_memory_selects_n)
    && $stable(display_select_n))) else $error("address moved under strobe");
  a_select_exclusive: assert property (@(posedge clk) disable iff (srst)
    !(!display_select_n && boot_memory_selects_n != ROM_SEL_IDLE))
    else $error("display and rom selected together");
endmodule
`default_nettype wire
